// [hdl/smo_cfg.svh]
// Constants for the two-wire slave with oscillator monitor.
// Assumes the bus sampling clock is much faster than the bus clock.
`ifndef SMO_CFG_SVH
`define SMO_CFG_SVH

// Clock rate and oscillator window
`define SMO_MCLK_MHZ      125
`define SMO_OSC_WIN_MS    250
`define SMO_OSC_WIN_CYC   (`SMO_OSC_WIN_MS * 1000 * `SMO_MCLK_MHZ)

// Bus addresses
`define SMO_ADDR_HI       3'h2
`define SMO_ADDR_ALL      7'h30
`define SMO_ADDR_ARA      7'h0c

// Register pointers
`define SMO_REG_INT       5'h00
`define SMO_REG_MASK      5'h01
`define SMO_REG_SUPPLY    5'h0a
`define SMO_REG_RESET     5'h1a

// Field positions and reset values
`define SMO_BIT_OSC       1
`define SMO_BIT_RESET_ALL 4
`define SMO_REG_RST       8'h00

`endif

// [hdl/smo_pkg.sv]
// Types shared by the two-wire slave.
// Assumes smo_cfg.svh holds the numeric constants.
package smo_pkg;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ADDR     = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_CMD      = 4'h3,
      ST_CMD_ACK  = 4'h4,
      ST_DATA     = 4'h5,
      ST_DATA_ACK = 4'h6,
      ST_TX       = 4'h7,
      ST_TX_ACK   = 4'h8,
      ST_SKIP     = 4'h9
   } smo_state_t;

   typedef enum logic [1:0] {
      XF_NONE  = 2'h0,
      XF_WRITE = 2'h1,
      XF_READ  = 2'h2,
      XF_ALERT = 2'h3
   } smo_xfer_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } smo_bus_t;

endpackage

// [hdl/smo_slave.sv]
// Two-wire slave, register file and oscillator presence monitor.
// Assumes link_clk oversamples the bus pins; osc comparators are async.
`timescale 1ns/10ps
`include "smo_cfg.svh"

// Functional notes
// - Missing oscillator with mask set sets supply event bit 1, raising interrupt.
// - Input valid only if below 0.6V and above 1.8V each 250ms.
// - Oscillator flag feeds only the interrupt and the supply register readback, not the AC disconnect.
// - Any reset sets the oscillator-missing flag.
// - After clearing, flag sets again only on invalid signal or reset.
// - AC-only channels turn off after disconnect timeout without stimulus.
// - Interrupt pin changes only between transactions; deferred until STOP.
// - Separate data input and output pins; output can drive optocoupler.
// - Only Write Byte, Read Byte and Receive Byte are supported.
// - Primary address is 010 plus four address-select pins.
// - Common address 0110000 also answered for writes.
// - Alert response address acknowledged only while interrupt is low.
// - START is SDA fall, STOP is SDA rise, while SCL high.
// - Acknowledge holds data line low through the ACK clock high.
// - Command byte acked; lower five bits load the pointer.
// - Write Byte data is acked and stored at the pointer.
// - Pointer cleared on every STOP.
// - Read Byte: command, repeated START, read address, data, nack, STOP.
// - Receive Byte returns the interrupt register at pointer zero.
// - Alert read sends own address, arbitrates, releases interrupt when done.
module smo_slave
   import smo_pkg::*;
#(
   parameter int OSC_WIN_CYC = `SMO_OSC_WIN_CYC
) (
   input  wire logic       mclk,             // Device clock
   input  wire logic       rst_n,            // Async reset, power-on or pin
   input  wire logic       link_clk,         // Bus sampling clock
   input  wire logic       scl,              // Bus clock pin
   input  wire logic       data_line_in,     // Data input pin
   output logic            data_line_out,    // Data output, 0 pulls low
   output logic            data_line_oe_n,   // Low while pulling low
   input  wire logic [3:0] addr_select_pins, // Low address bits
   input  wire logic       osc_below_lo,     // Stimulus below low threshold
   input  wire logic       osc_above_hi,     // Stimulus above high threshold
   output logic            int_n,            // Interrupt, active low
   output logic            osc_absent        // Stimulus missing, to AC disconnect
);

   localparam int WW = $clog2(OSC_WIN_CYC);

   // ---------------- Device clock domain ----------------
   logic          lo_s1_reg, lo_s2_reg, hi_s1_reg, hi_s2_reg;
   logic          seen_lo_reg, seen_hi_reg;
   logic [WW-1:0] win_cnt_reg;
   logic          osc_fail_reg, osc_absent_reg, int_req_m_reg;
   logic          mask_s1_reg, mask_s2_reg;
   logic          clr_s1_reg, clr_s2_reg, clr_s3_reg;
   logic          rsa_s1_reg, rsa_s2_reg, rsa_s3_reg;
   logic          clr_tog_reg, rsa_tog_reg;
   logic [7:0]    mem_reg [0:31];
   wire           mask_l = mem_reg[`SMO_REG_MASK][`SMO_BIT_OSC];

   wire win_end   = (win_cnt_reg == WW'(OSC_WIN_CYC - 1));
   wire any_lo    = seen_lo_reg | lo_s2_reg;
   wire any_hi    = seen_hi_reg | hi_s2_reg;
   wire osc_bad   = win_end & ~(any_lo & any_hi);
   wire clr_pulse = clr_s2_reg ^ clr_s3_reg;
   wire rsa_pulse = rsa_s2_reg ^ rsa_s3_reg;
   wire osc_set   = rsa_pulse | (osc_bad & mask_s2_reg);
   wire osc_fail_next = osc_set | (osc_fail_reg & ~clr_pulse);

   // Comparator outputs and link-side controls cross here
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lo_s1_reg   <= 1'b0;
         lo_s2_reg   <= 1'b0;
         hi_s1_reg   <= 1'b0;
         hi_s2_reg   <= 1'b0;
         mask_s1_reg <= 1'b0;
         mask_s2_reg <= 1'b0;
         clr_s1_reg  <= 1'b0;
         clr_s2_reg  <= 1'b0;
         clr_s3_reg  <= 1'b0;
         rsa_s1_reg  <= 1'b0;
         rsa_s2_reg  <= 1'b0;
         rsa_s3_reg  <= 1'b0;
      end else begin
         lo_s1_reg   <= osc_below_lo;
         lo_s2_reg   <= lo_s1_reg;
         hi_s1_reg   <= osc_above_hi;
         hi_s2_reg   <= hi_s1_reg;
         mask_s1_reg <= mask_l;
         mask_s2_reg <= mask_s1_reg;
         clr_s1_reg  <= clr_tog_reg;
         clr_s2_reg  <= clr_s1_reg;
         clr_s3_reg  <= clr_s2_reg;
         rsa_s1_reg  <= rsa_tog_reg;
         rsa_s2_reg  <= rsa_s1_reg;
         rsa_s3_reg  <= rsa_s2_reg;
      end
   end

   // Window of both threshold crossings
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_reg    <= '0;
         seen_lo_reg    <= 1'b0;
         seen_hi_reg    <= 1'b0;
         osc_absent_reg <= 1'b0;
      end else begin
         win_cnt_reg    <= win_end ? '0 : win_cnt_reg + 1'b1;
         seen_lo_reg    <= ~win_end & any_lo;
         seen_hi_reg    <= ~win_end & any_hi;
         if (win_end) begin
            osc_absent_reg <= osc_bad;
         end
      end
   end

   // Flag set by reset; set wins over clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_fail_reg  <= 1'b1;
         int_req_m_reg <= 1'b0;
      end else begin
         osc_fail_reg  <= osc_fail_next;
         int_req_m_reg <= osc_fail_reg & mask_s2_reg;
      end
   end

   assign osc_absent = osc_absent_reg;

   // ---------------- Link clock domain ----------------
   smo_bus_t   bus_s1_reg, bus_s2_reg, bus_s3_reg;
   logic [3:0] ad_s1_reg, ad_s2_reg;
   logic       of_s1_reg, of_s2_reg, ir_s1_reg, ir_s2_reg;
   smo_state_t state_reg, state_next;
   smo_xfer_t  xfer_reg, xfer_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [4:0] ptr_reg, ptr_next;
   logic       dout_reg, dout_next;
   logic       busy_reg, busy_next;
   logic       alert_done_reg, alert_done_next;
   logic       int_n_reg;

   wire start_det = bus_s2_reg.scl & bus_s3_reg.scl & bus_s3_reg.sda & ~bus_s2_reg.sda;
   wire stop_det  = bus_s2_reg.scl & bus_s3_reg.scl & ~bus_s3_reg.sda & bus_s2_reg.sda;
   wire scl_rise  = ~bus_s3_reg.scl & bus_s2_reg.scl;
   wire scl_fall  = bus_s3_reg.scl & ~bus_s2_reg.scl;
   wire byte_end  = scl_fall & (cnt_reg == 4'h8);
   wire sda_in    = bus_s2_reg.sda;

   wire [6:0] rx_addr = shift_reg[7:1];
   wire       rx_rd   = shift_reg[0];
   wire       hit_own = (rx_addr == {`SMO_ADDR_HI, ad_s2_reg});
   wire       hit_all = (rx_addr == `SMO_ADDR_ALL) & ~rx_rd;
   wire       hit_ara = (rx_addr == `SMO_ADDR_ARA) & rx_rd & ~int_n_reg;
   wire       addr_hit = hit_own | hit_all | hit_ara;
   wire smo_xfer_t xfer_sel = hit_ara ? XF_ALERT : (rx_rd ? XF_READ : XF_WRITE);

   wire [7:0] int_sum  = 8'(ir_s2_reg) << `SMO_BIT_OSC;
   wire [7:0] sup_val  = 8'(of_s2_reg) << `SMO_BIT_OSC;
   wire [7:0] read_val = (ptr_reg == `SMO_REG_INT)    ? int_sum :
                         (ptr_reg == `SMO_REG_SUPPLY) ? sup_val : mem_reg[ptr_reg];
   wire [7:0] tx_alert = {`SMO_ADDR_HI, ad_s2_reg, 1'b1};
   wire [7:0] tx_load  = (xfer_reg == XF_ALERT) ? tx_alert : read_val;
   wire       wr_stb   = (state_reg == ST_DATA) & byte_end & ~start_det & ~stop_det;
   wire       clr_req  = wr_stb & (ptr_reg == `SMO_REG_SUPPLY) & shift_reg[`SMO_BIT_OSC];
   wire       rsa_req  = wr_stb & (ptr_reg == `SMO_REG_RESET) & shift_reg[`SMO_BIT_RESET_ALL];
   wire       arb_lost = (xfer_reg == XF_ALERT) & scl_rise & shift_reg[7] & ~sda_in;

   // Pin samples from the bus and the device clock domain
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_s1_reg <= '{scl: 1'b1, sda: 1'b1};
         bus_s2_reg <= '{scl: 1'b1, sda: 1'b1};
         bus_s3_reg <= '{scl: 1'b1, sda: 1'b1};
         ad_s1_reg  <= 4'h0;
         ad_s2_reg  <= 4'h0;
         of_s1_reg  <= 1'b0;
         of_s2_reg  <= 1'b0;
         ir_s1_reg  <= 1'b0;
         ir_s2_reg  <= 1'b0;
      end else begin
         bus_s1_reg <= '{scl: scl, sda: data_line_in};
         bus_s2_reg <= bus_s1_reg;
         bus_s3_reg <= bus_s2_reg;
         ad_s1_reg  <= addr_select_pins;
         ad_s2_reg  <= ad_s1_reg;
         of_s1_reg  <= osc_fail_reg;
         of_s2_reg  <= of_s1_reg;
         ir_s1_reg  <= int_req_m_reg;
         ir_s2_reg  <= ir_s1_reg;
      end
   end

   // Transaction sequencer
   always_comb begin
      state_next      = state_reg;
      xfer_next       = xfer_reg;
      cnt_next        = cnt_reg;
      shift_next      = shift_reg;
      ptr_next        = ptr_reg;
      dout_next       = dout_reg;
      busy_next       = busy_reg;
      alert_done_next = alert_done_reg & ir_s2_reg;
      if (stop_det) begin
         state_next = ST_IDLE;
         ptr_next   = 5'h00;
         dout_next  = 1'b1;
         busy_next  = 1'b0;
         xfer_next  = XF_NONE;
      end else if (start_det) begin
         state_next = ST_ADDR;
         cnt_next   = 4'h0;
         dout_next  = 1'b1;
         busy_next  = 1'b1;
      end else begin
         unique case (state_reg)
            ST_ADDR, ST_CMD, ST_DATA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_in};
                  cnt_next   = cnt_reg + 4'h1;
               end else if (byte_end) begin
                  cnt_next = 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (addr_hit) begin
                        state_next = ST_ADDR_ACK;
                        xfer_next  = xfer_sel;
                        dout_next  = 1'b0;
                     end else begin
                        state_next = ST_SKIP;
                     end
                  end else if (state_reg == ST_CMD) begin
                     ptr_next   = shift_reg[4:0];
                     state_next = ST_CMD_ACK;
                     dout_next  = 1'b0;
                  end else begin
                     state_next = ST_DATA_ACK;
                     dout_next  = 1'b0;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_next = 4'h0;
                  if (xfer_reg == XF_WRITE) begin
                     state_next = ST_CMD;
                     dout_next  = 1'b1;
                  end else begin
                     state_next = ST_TX;
                     shift_next = tx_load;
                     dout_next  = tx_load[7];
                  end
               end
            end
            ST_CMD_ACK: begin
               if (scl_fall) begin
                  state_next = ST_DATA;
                  cnt_next   = 4'h0;
                  dout_next  = 1'b1;
               end
            end
            ST_DATA_ACK: begin
               if (scl_fall) begin
                  state_next = ST_SKIP;
                  dout_next  = 1'b1;
               end
            end
            ST_TX: begin
               if (arb_lost) begin
                  state_next = ST_SKIP;
                  dout_next  = 1'b1;
               end else if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (byte_end) begin
                  state_next = ST_TX_ACK;
                  dout_next  = 1'b1;
                  if (xfer_reg == XF_ALERT) begin
                     alert_done_next = 1'b1;
                  end
               end else if (scl_fall) begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  dout_next  = shift_reg[6];
               end
            end
            ST_TX_ACK: begin
               if (scl_rise && sda_in) begin
                  state_next = ST_SKIP;
               end else if (scl_fall) begin
                  state_next = ST_TX;
                  cnt_next   = 4'h0;
                  shift_next = tx_load;
                  dout_next  = tx_load[7];
               end
            end
            ST_IDLE, ST_SKIP: begin
               dout_next = 1'b1;
            end
            default: begin
               state_next = ST_SKIP;
               dout_next  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         xfer_reg       <= XF_NONE;
         cnt_reg        <= 4'h0;
         shift_reg      <= 8'h00;
         ptr_reg        <= 5'h00;
         dout_reg       <= 1'b1;
         busy_reg       <= 1'b0;
         alert_done_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         xfer_reg       <= xfer_next;
         cnt_reg        <= cnt_next;
         shift_reg      <= shift_next;
         ptr_reg        <= ptr_next;
         dout_reg       <= dout_next;
         busy_reg       <= busy_next;
         alert_done_reg <= alert_done_next;
      end
   end

   // Interrupt pin moves only while the bus is free
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_n_reg <= 1'b1;
      end else if (!busy_reg) begin
         int_n_reg <= ~(ir_s2_reg & ~alert_done_reg);
      end
   end

   // Write-one actions cross to the device clock as toggles
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_tog_reg <= 1'b0;
         rsa_tog_reg <= 1'b0;
      end else begin
         clr_tog_reg <= clr_tog_reg ^ clr_req;
         rsa_tog_reg <= rsa_tog_reg ^ rsa_req;
      end
   end

   generate
      for (genvar i = 0; i < 32; i++) begin : g_mem
         always_ff @(posedge link_clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_reg[i] <= `SMO_REG_RST;
            end else if (wr_stb && ptr_reg == 5'(i)) begin
               mem_reg[i] <= shift_reg;
            end
         end
      end
   endgenerate

   assign data_line_out  = dout_reg;
   assign data_line_oe_n = dout_reg;
   assign int_n          = int_n_reg;

   // ---------------- Checks ----------------
   wire ctl_ok = ~start_det & ~stop_det;

   stop_ptr_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      stop_det |=> ptr_reg == 5'h00) else $error("pointer not cleared by stop");
   addr_ack_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      (((state_reg == ST_ADDR && byte_end && addr_hit) || (state_reg == ST_ADDR_ACK && !scl_fall)) && ctl_ok)
      |=> (state_reg == ST_ADDR_ACK && !data_line_out)) else $error("address ack not held");
   miss_free_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      (state_reg == ST_ADDR && byte_end && !addr_hit && ctl_ok) |=> state_reg == ST_SKIP && data_line_out)
      else $error("unmatched address not ignored");
   cmd_ptr_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      (state_reg == ST_CMD && byte_end && ctl_ok) |=> ptr_reg == $past(shift_reg[4:0]))
      else $error("pointer not loaded from command");
   int_quiet_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      busy_reg |=> $stable(int_n_reg)) else $error("interrupt moved during transaction");
   ara_gate_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      (state_reg == ST_ADDR_ACK && xfer_reg == XF_ALERT) |-> !int_n_reg)
      else $error("alert address acked without interrupt");
   arb_lost_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      (state_reg == ST_TX && arb_lost && ctl_ok) |=> state_reg == ST_SKIP && data_line_out)
      else $error("arbitration loss not handled");
   osc_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (osc_bad && mask_s2_reg) |=> osc_fail_reg ##1 int_req_m_reg)
      else $error("missing oscillator not flagged");
   soft_rst_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rsa_pulse |=> osc_fail_reg) else $error("reset-all did not set flag");
   osc_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (!osc_fail_reg && !osc_set) |=> !osc_fail_reg) else $error("flag set without cause");

   wr_done_c: cover property (@(posedge link_clk) disable iff (!rst_n) wr_stb);
   rd_ack_c: cover property (@(posedge link_clk) disable iff (!rst_n)
      state_reg == ST_TX && xfer_reg == XF_READ && byte_end);
   alert_c: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(alert_done_reg));
   osc_miss_c: cover property (@(posedge mclk) disable iff (!rst_n) osc_bad && mask_s2_reg);

endmodule

// [tb/smo_host.sv]
// Bus master model that drives the clock and data lines of the two-wire slave.
// Assumes an external pull-up, so the wire is the AND of all drivers.
`timescale 1ns/10ps
module smo_host (
   input  wire logic mclk,     // Timing reference
   input  wire logic sda,      // Resolved data line
   output logic      scl,      // Bus clock, idles high
   output logic      sda_o,    // Data drive, 0 pulls low
   output logic [7:0] rd_byte, // Last byte read
   output logic      rd_valid  // One-cycle pulse per byte read
);
   localparam int HALF = 20;

   initial begin
      scl = 1'b1;
      sda_o = 1'b1;
      rd_byte = 8'h00;
      rd_valid = 1'b0;
   end

   task automatic wait_c(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Also serves as repeated START
   task automatic start();
      sda_o <= 1'b1;
      wait_c(HALF / 2);
      scl <= 1'b1;
      wait_c(HALF);
      sda_o <= 1'b0;
      wait_c(HALF);
      scl <= 1'b0;
      wait_c(HALF / 2);
   endtask

   task automatic stop();
      sda_o <= 1'b0;
      wait_c(HALF / 2);
      scl <= 1'b1;
      wait_c(HALF);
      sda_o <= 1'b1;
      wait_c(HALF);
   endtask

   task automatic bit_x(input logic b, output logic s);
      sda_o <= b;
      wait_c(HALF / 2);
      scl <= 1'b1;
      wait_c(HALF / 2);
      s = sda;
      wait_c(HALF / 2);
      scl <= 1'b0;
      wait_c(HALF / 2);
   endtask

   // Reads send 8'hff and answer 1: the last byte is never acknowledged
   task automatic xfer(input logic [7:0] d, input logic rd, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(1'b1, ack);
      if (rd) begin
         rd_byte <= q;
         rd_valid <= 1'b1;
         wait_c(1);
         rd_valid <= 1'b0;
      end
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the two-wire slave with oscillator monitor.
// Assumes smo_slave and the host model; read results are checked from a queue.
`timescale 1ns/10ps
module testbench;
   import smo_pkg::*;

   logic        mclk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  pins = 4'h0;
   logic        osc_lo = 1'b0;
   logic        osc_hi = 1'b0;
   logic        osc_run = 1'b1;
   logic [31:0] rs = 32'h4b257262;
   logic [7:0]  exp_q[$];
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   wire         scl;
   wire         host_sda;
   wire         out;
   wire         oe_n;
   wire         int_n;
   wire         osc_absent;
   wire [7:0]   rd_byte;
   wire         rd_valid;
   wire         sda = host_sda & out;

   always #4 mclk = ~mclk;
   initial #3 forever #16 link_clk = ~link_clk;

   smo_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_o(host_sda), .rd_byte(rd_byte), .rd_valid(rd_valid));

   smo_slave #(.OSC_WIN_CYC(64)) uut (
      .mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .scl(scl), .data_line_in(sda),
      .data_line_out(out), .data_line_oe_n(oe_n), .addr_select_pins(pins),
      .osc_below_lo(osc_lo), .osc_above_hi(osc_hi), .int_n(int_n), .osc_absent(osc_absent));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask

   task automatic end_of_test();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Random stimulus crossing both thresholds while running
   always @(posedge mclk) begin
      rs <= xs(rs);
      osc_lo <= osc_run & rs[0];
      osc_hi <= osc_run & rs[1] & ~rs[0];
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         end_of_test();
      end
   end

   always @(posedge mclk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0)
            check(rd_byte, 8'hxx);
         else
            check(rd_byte, exp_q.pop_front());
      end
   end

   task automatic write_byte(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic ok);
      logic [7:0] q;
      logic [2:0] k;
      host.start();
      host.xfer({a, 1'b0}, 1'b0, q, k[2]);
      host.xfer(c, 1'b0, q, k[1]);
      host.xfer(d, 1'b0, q, k[0]);
      host.stop();
      check({5'h0, k}, ok ? 8'h00 : 8'h07);
   endtask

   task automatic read_reg(input logic [6:0] a, input logic cmd, input logic [7:0] c, input logic [7:0] exp,
                           input logic ok);
      logic [7:0] q;
      logic [3:0] k;
      k = 4'h0;
      host.start();
      if (cmd) begin
         host.xfer({a, 1'b0}, 1'b0, q, k[3]);
         host.xfer(c, 1'b0, q, k[2]);
         host.start();
      end
      if (ok)
         exp_q.push_back(exp);
      host.xfer({a, 1'b1}, 1'b0, q, k[1]);
      host.xfer(8'hff, ok, q, k[0]);
      host.stop();
      check({6'h0, oe_n, out}, 8'h03);
      check({4'h0, k}, ok ? 8'h01 : 8'h03);
   endtask

   task automatic wait_int(input logic v);
      for (int i = 0; i < 300 && int_n !== v; i++)
         @(posedge mclk);
      check({7'h0, int_n}, {7'h0, v});
   endtask

   logic [6:0] pa;
   logic [7:0] aq;
   logic       ak;
   initial begin
      repeat (20) @(posedge mclk);
      pins <= rs[5:2];
      rst_n <= 1'b1;
      repeat (20) @(posedge mclk);
      pa = {3'b010, pins};
      check({7'h0, int_n}, 8'h01);
      read_reg(pa, 1'b0, 8'h00, 8'h00, 1'b1);
      read_reg(pa, 1'b1, 8'h0a, 8'h02, 1'b1);
      write_byte(pa, 8'he1, 8'h02, 1'b1);
      wait_int(1'b0);
      read_reg(pa, 1'b0, 8'h00, 8'h02, 1'b1);
      read_reg(7'h0c, 1'b0, 8'h00, {3'b010, pins, 1'b1}, 1'b1);
      wait_int(1'b1);
      read_reg(7'h0c, 1'b0, 8'h00, 8'h00, 1'b0);
      write_byte({3'b010, ~pins}, 8'h01, 8'h00, 1'b0);
      write_byte(7'h30, 8'h0a, 8'h02, 1'b1);
      repeat (200) @(posedge mclk);
      check({7'h0, osc_absent}, 8'h00);
      read_reg(pa, 1'b1, 8'h0a, 8'h00, 1'b1);
      write_byte(pa, 8'h1a, 8'h10, 1'b1);
      read_reg(pa, 1'b1, 8'h0a, 8'h02, 1'b1);
      write_byte(pa, 8'h0a, 8'h02, 1'b1);
      wait_int(1'b1);
      osc_run <= 1'b0;
      repeat (200) @(posedge mclk);
      check({7'h0, osc_absent}, 8'h01);
      read_reg(pa, 1'b1, 8'h0a, 8'h02, 1'b1);
      wait_int(1'b0);
      // Another responder wins at the second address bit
      host.start();
      host.xfer({7'h0c, 1'b1}, 1'b0, aq, ak);
      check({7'h0, ak}, 8'h00);
      host.xfer(8'h3f, 1'b0, aq, ak);
      check(aq, 8'h3f);
      host.stop();
      check({7'h0, int_n}, 8'h00);
      read_reg(7'h0c, 1'b0, 8'h00, {3'b010, pins, 1'b1}, 1'b1);
      wait_int(1'b1);
      osc_run <= 1'b1;
      repeat (200) @(posedge mclk);
      check({7'h0, osc_absent}, 8'h00);
      end_of_test();
   end
endmodule
